// >>> hw/rsc_cfg.svh
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

`define RSC_FRAME_W    16
`define RSC_CMD_HI     15
`define RSC_CMD_LO     12
`define RSC_SUB_HI     2
`define RSC_SUB_LO     0
`define RSC_CMD_CTRL   4'h2
`define RSC_CMD_CFG    4'h4
`define RSC_CMD_CFGREQ 4'h7
`define RSC_CMD_STREQ  4'h8
`define RSC_SUB_B      3'h1
`define RSC_SUB_E      3'h4
`define RSC_SUB_A      3'h0
`define RSC_SWR_HI     10
`define RSC_SWR_LO     9
`define RSC_SWR_GO     2'h1
`define RSC_TRIG_BIT   8
`define RSC_SPREAD_BIT 2
`define RSC_FLAG_BIT   11
`define RSC_ST_HI      8
`define RSC_ST_LO      6
`define RSC_ST_PASS    3'h7
`define RSC_ST_FAIL    3'h4
`define RSC_ST_NONE    3'h0
`define RSC_SW_RST_CYC 2'h2
`define RSC_BIT_CNT_W  5
`define RSC_FRAME_BITS 5'h10
`define RSC_CNT_W      16
`define RSC_CLK_MHZ    50
`define RSC_T_POR_US   300
`define RSC_T_FIL_US   50
`define RSC_T_REF_US   100
`define RSC_T_DUR_US   130
`define RSC_POR_CYC    (`RSC_T_POR_US * `RSC_CLK_MHZ)
`define RSC_FIL_CYC    (`RSC_T_FIL_US * `RSC_CLK_MHZ)
`define RSC_REF_CYC    (`RSC_T_REF_US * `RSC_CLK_MHZ)
`define RSC_DUR_CYC    (`RSC_T_DUR_US * `RSC_CLK_MHZ)

`endif

// >>> hw/rsc_pkg.sv
`include "rsc_cfg.svh"
package rsc_pkg;
  typedef enum logic [2:0] {
    SC_IDLE = 3'h1,
    SC_RUN  = 3'h2,
    SC_DONE = 3'h4
  } rsc_check_e;
  typedef logic [`RSC_FRAME_W-1:0] rsc_frame_t;
  typedef logic [`RSC_ST_HI-`RSC_ST_LO:0] rsc_status_t;
endpackage

// >>> hw/rsc_frame_if.sv
`timescale 1ns/1ps
interface rsc_frame_if;
  rsc_pkg::rsc_frame_t rx_word;
  logic                rx_valid;
  rsc_pkg::rsc_frame_t tx_word;
  modport link (output rx_word, output rx_valid, input tx_word);
  modport core (input rx_word, input rx_valid, output tx_word);
endinterface

// >>> hw/rsc_timer.sv
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_timer #(
  parameter int unsigned COUNT = 1
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic restart,
  input  wire logic enable,
  output logic      expired
);
  localparam logic [`RSC_CNT_W-1:0] LAST = `RSC_CNT_W'(COUNT - 1);

  logic [`RSC_CNT_W-1:0] cnt_q, cnt_d;
  logic                  exp_q, exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (restart) begin
      cnt_d = '0;
      exp_d = 1'h0;
    end else if (enable && !exp_q) begin
      if (cnt_q == LAST) begin
        exp_d = 1'h1;
      end
      cnt_d = cnt_q + `RSC_CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= '0;
      exp_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

  a_timer_count: assert property (@(posedge clock) disable iff (!rstn) // [R23]
    $rose(exp_q) |-> ($past(cnt_q) == LAST && $past(enable)))
    else $error("Timer expired at wrong count");
endmodule

// >>> hw/rsc_spi_link.sv
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_spi_link (
  input  wire logic   clock,
  input  wire logic   rstn,
  input  wire logic   sclk,
  input  wire logic   cs_n,
  input  wire logic   sdi,
  output logic        sdo,
  output logic        sdo_oe,
  rsc_frame_if.link   frame
);
  logic                     sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic                     cs_s1_q, cs_s2_q, cs_s3_q;
  logic                     sdi_s1_q, sdi_s2_q;
  rsc_pkg::rsc_frame_t      rx_q, rx_d, tx_q, tx_d;
  logic [`RSC_BIT_CNT_W-1:0] cnt_q, cnt_d;
  logic                     valid_q, valid_d;
  logic                     rise, fall, start, stop;

  // Sclk is slow against our clock, so plain three-flop sampling finds its edges
  always_ff @(posedge clock) begin
    sclk_s1_q <= sclk;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    cs_s1_q   <= cs_n;
    cs_s2_q   <= cs_s1_q;
    cs_s3_q   <= cs_s2_q;
    sdi_s1_q  <= sdi;
    sdi_s2_q  <= sdi_s1_q;
  end

  assign rise  = sclk_s2_q & ~sclk_s3_q;
  assign fall  = ~sclk_s2_q & sclk_s3_q;
  assign start = cs_s3_q & ~cs_s2_q;
  assign stop  = ~cs_s3_q & cs_s2_q;

  always_comb begin
    rx_d    = rx_q;
    tx_d    = tx_q;
    cnt_d   = cnt_q;
    valid_d = 1'h0;
    if (start) begin
      tx_d  = frame.tx_word;
      cnt_d = '0;
    end else if (!cs_s2_q) begin
      if (rise) begin
        rx_d = {rx_q[`RSC_FRAME_W-2:0], sdi_s2_q};
        if (cnt_q != `RSC_FRAME_BITS + 5'h1) begin
          cnt_d = cnt_q + 5'h1;
        end
      end
      if (fall) begin
        tx_d = {tx_q[`RSC_FRAME_W-2:0], 1'h0};
      end
    end
    // Frames of the wrong length are dropped whole
    if (stop && cnt_q == `RSC_FRAME_BITS) begin
      valid_d = 1'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rx_q    <= '0;
      tx_q    <= '0;
      cnt_q   <= '0;
      valid_q <= 1'h0;
    end else begin
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
    end
  end

  assign sdo            = tx_q[`RSC_FRAME_W-1];
  assign sdo_oe         = ~cs_s2_q;
  assign frame.rx_word  = rx_q;
  assign frame.rx_valid = valid_q;
endmodule

// >>> hw/rsc_top.sv
// Contract
// [R1] Supply reset low forces bridge tri-state
// [R2] Any internal reset keeps bridge tri-state
// [R3] Leaving reset restores default configuration
// [R4] Reset released within 300 us of supply
// [R5] Frame 2 code 01 resets; others ignored
// [R6] Software reset lasts exactly two clocks
// [R7] Reset entered at once from either source
// [R8] Reset asserts asynchronously, releases synchronously
// [R9] Software reset never touches supply reset
// [R10] Reset flag set by reset, read clears
// [R11] Spread disable setting, default 0, echoed
// [R12] Bridge tri-state until self-check done
// [R13] Trigger accepted only after reset or fail
// [R14] Start lowers threshold, starts three timers
// [R15] Over-voltage at filter end means pass
// [R16] No over-voltage at filter end fails
// [R17] Filter unfinished at reference end fails
// [R18] Reference end restores normal threshold
// [R19] Comparator rising edge restarts filter timer
// [R20] After pass, first PWM edge enables bridge
// [R21] Duration end sets done regardless
// [R22] Status code: 0xx, 100 fail, 111 pass
// [R23] All timing counted on system clock
`timescale 1ns/1ps
`include "rsc_cfg.svh"
module rsc_top #(
  parameter int unsigned REF_CYC = `RSC_REF_CYC,
  parameter int unsigned DUR_CYC = `RSC_DUR_CYC
) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic por_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  input  wire logic ov_comp,
  input  wire logic pwm,
  output logic      bridge_tristate,
  output logic      ov_threshold_lower,
  output logic      spread_disable,
  output logic      self_check_done,
  output logic      por_rst_n,
  output logic      int_rst_n
);
  localparam int unsigned FIL_CYC = `RSC_FIL_CYC;
  rsc_frame_if frame ();
  logic                por_s1_q, por_s2_q;
  logic [1:0]          swcnt_q, swcnt_d;
  logic                sw_active, core_rst, link_rstn;
  logic                ov_s1_q, ov_s2_q, ov_s3_q;
  logic                pwm_s1_q, pwm_s2_q, pwm_s3_q;
  logic                ov_rise, pwm_edge;
  rsc_pkg::rsc_check_e sc_state_q, sc_state_d;
  logic                verdict_q, verdict_d, pass_q, pass_d;
  logic                lower_q, lower_d;
  logic                fil_exp, ref_exp, dur_exp, fil_restart, run;
  logic                armed_q, armed_d, passed;
  logic                spread_q, spread_d, flag_q, flag_d;
  rsc_pkg::rsc_frame_t tx_q, tx_d;
  rsc_pkg::rsc_status_t status;
  logic                sw_req, trig_req, trig_ok, start, read_flag;

  function automatic logic is_cmd(input rsc_pkg::rsc_frame_t w, input logic [3:0] code);
    is_cmd = (w[`RSC_CMD_HI:`RSC_CMD_LO] == code);
  endfunction
  function automatic logic is_sub(input rsc_pkg::rsc_frame_t w, input logic [2:0] code);
    is_sub = (w[`RSC_SUB_HI:`RSC_SUB_LO] == code);
  endfunction
  // Supply reset: clears at once, releases through two flops
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      por_s1_q <= 1'h0; // [R8]
      por_s2_q <= 1'h0;
    end else begin
      por_s1_q <= 1'h1;
      por_s2_q <= por_s1_q; // [R4]
    end
  end

  // Only the supply drives this output
  assign por_rst_n = por_s2_q; // [R9]

  always_comb begin
    swcnt_d = swcnt_q;
    if (!rstn || !por_s2_q) begin
      swcnt_d = 2'h0;
    end else if (sw_req) begin
      swcnt_d = `RSC_SW_RST_CYC; // [R6]
    end else if (swcnt_q != 2'h0) begin
      swcnt_d = swcnt_q - 2'h1;
    end
  end

  always_ff @(posedge clock) begin
    swcnt_q <= swcnt_d;
  end
  assign sw_active = (swcnt_q != 2'h0);
  // Supply pin feeds the output directly so reset takes hold without a clock
  assign int_rst_n = por_n & por_s2_q & ~sw_active; // [R7] [R8]
  assign core_rst  = !rstn || !por_s2_q || sw_active;
  // Link survives a software reset so the answer frame is not torn
  assign link_rstn = rstn & por_s2_q;
  always_ff @(posedge clock) begin
    ov_s1_q  <= ov_comp;
    ov_s2_q  <= ov_s1_q;
    ov_s3_q  <= ov_s2_q;
    pwm_s1_q <= pwm;
    pwm_s2_q <= pwm_s1_q;
    pwm_s3_q <= pwm_s2_q;
  end

  assign ov_rise  = ov_s2_q & ~ov_s3_q;
  assign pwm_edge = pwm_s2_q ^ pwm_s3_q;
  rsc_spi_link u_link (.clock(clock), .rstn(link_rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
                       .sdo(sdo), .sdo_oe(sdo_oe), .frame(frame.link));
  // Command decode
  always_comb begin
    sw_req    = 1'h0;
    trig_req  = 1'h0;
    read_flag = 1'h0;
    if (frame.rx_valid && is_cmd(frame.rx_word, `RSC_CMD_CTRL)) begin
      sw_req   = (frame.rx_word[`RSC_SWR_HI:`RSC_SWR_LO] == `RSC_SWR_GO); // [R5]
      // A reset in the same frame wins over the trigger
      trig_req = frame.rx_word[`RSC_TRIG_BIT] && !sw_req;
    end else if (frame.rx_valid && is_cmd(frame.rx_word, `RSC_CMD_CFGREQ)) begin
      read_flag = is_sub(frame.rx_word, `RSC_SUB_E);
    end
  end

  assign run     = (sc_state_q == rsc_pkg::SC_RUN);
  assign trig_ok = (sc_state_q == rsc_pkg::SC_IDLE) ||
                   (sc_state_q == rsc_pkg::SC_DONE && !pass_q); // [R13]
  assign start   = trig_req && trig_ok && !core_rst;
  assign passed  = (sc_state_q == rsc_pkg::SC_DONE) && pass_q;
  // Restarts stop mattering once a verdict is in
  assign fil_restart = start || (run && ov_rise && !verdict_q); // [R19]
  rsc_timer #(.COUNT(FIL_CYC)) u_fil (.clock(clock), .rstn(!core_rst), .restart(fil_restart),
                                     .enable(run), .expired(fil_exp));
  rsc_timer #(.COUNT(REF_CYC)) u_ref (.clock(clock), .rstn(!core_rst), .restart(start),
                                     .enable(run), .expired(ref_exp)); // [R14]
  rsc_timer #(.COUNT(DUR_CYC)) u_dur (.clock(clock), .rstn(!core_rst), .restart(start),
                                     .enable(run), .expired(dur_exp));
  // Self-check sequence
  always_comb begin
    sc_state_d = sc_state_q;
    verdict_d  = verdict_q;
    pass_d     = pass_q;
    lower_d    = lower_q;
    case (sc_state_q)
      rsc_pkg::SC_IDLE: begin
        if (start) begin
          sc_state_d = rsc_pkg::SC_RUN;
        end
      end
      rsc_pkg::SC_RUN: begin
        if (fil_exp && !verdict_q) begin
          verdict_d = 1'h1;
          pass_d    = ov_s2_q; // [R15] [R16]
        end else if (ref_exp && !verdict_q) begin
          verdict_d = 1'h1;
          pass_d    = 1'h0; // [R17]
        end
        if (ref_exp) begin
          lower_d = 1'h0; // [R18]
        end
        if (dur_exp) begin
          sc_state_d = rsc_pkg::SC_DONE; // [R21]
          lower_d    = 1'h0;
        end
      end
      rsc_pkg::SC_DONE: begin
        if (start) begin
          sc_state_d = rsc_pkg::SC_RUN;
        end
      end
      default: begin
        sc_state_d = rsc_pkg::SC_IDLE;
      end
    endcase
    if (start) begin
      verdict_d = 1'h0;
      pass_d    = 1'h0;
      lower_d   = 1'h1; // [R14]
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      sc_state_q <= rsc_pkg::SC_IDLE;
      verdict_q  <= 1'h0;
      pass_q     <= 1'h0;
      lower_q    <= 1'h0;
    end else begin
      sc_state_q <= sc_state_d;
      verdict_q  <= verdict_d;
      pass_q     <= pass_d;
      lower_q    <= lower_d;
    end
  end
  assign status = (sc_state_q != rsc_pkg::SC_DONE) ? `RSC_ST_NONE :
                  pass_q ? `RSC_ST_PASS : `RSC_ST_FAIL; // [R22]
  // Bridge arming waits for a PWM edge after a pass
  always_comb begin
    armed_d = armed_q;
    if (!passed) begin
      armed_d = 1'h0;
    end else if (pwm_edge) begin
      armed_d = 1'h1; // [R20]
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      armed_q <= 1'h0;
    end else begin
      armed_q <= armed_d;
    end
  end
  assign bridge_tristate = !por_n || !por_s2_q || sw_active || !rstn || !armed_q; // [R1] [R2] [R12]
  // Registers and answer word
  always_comb begin
    spread_d = spread_q;
    flag_d   = flag_q;
    tx_d     = tx_q;
    if (read_flag) begin
      flag_d = 1'h0; // [R10]
    end
    if (frame.rx_valid) begin
      tx_d = '0;
      tx_d[`RSC_CMD_HI:`RSC_CMD_LO] = frame.rx_word[`RSC_CMD_HI:`RSC_CMD_LO];
      if (is_cmd(frame.rx_word, `RSC_CMD_CFG)) begin
        spread_d = frame.rx_word[`RSC_SPREAD_BIT]; // [R11]
        tx_d[`RSC_SPREAD_BIT] = frame.rx_word[`RSC_SPREAD_BIT];
      end else if (is_cmd(frame.rx_word, `RSC_CMD_CFGREQ)) begin
        if (is_sub(frame.rx_word, `RSC_SUB_B)) begin
          tx_d[`RSC_SPREAD_BIT] = spread_q; // [R11]
        end else if (is_sub(frame.rx_word, `RSC_SUB_E)) begin
          tx_d[`RSC_FLAG_BIT] = flag_q;
        end
      end else if (is_cmd(frame.rx_word, `RSC_CMD_STREQ)) begin
        if (is_sub(frame.rx_word, `RSC_SUB_A)) begin
          tx_d[`RSC_ST_HI:`RSC_ST_LO] = status;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      spread_q <= 1'h0; // [R3]
      flag_q   <= 1'h1; // [R10]
    end else begin
      spread_q <= spread_d;
      flag_q   <= flag_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!link_rstn) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  assign frame.tx_word      = tx_q;
  assign spread_disable     = spread_q;
  assign ov_threshold_lower = lower_q;
  assign self_check_done    = (sc_state_q == rsc_pkg::SC_DONE);
  a_por_tristate: assert property (@(posedge clock) // [R1]
    !por_n |-> bridge_tristate)
    else $error("Bridge driven under supply reset");
  a_rst_tristate: assert property (@(posedge clock) disable iff (!rstn) // [R2]
    !int_rst_n |-> bridge_tristate)
    else $error("Bridge driven under internal reset");
  a_spread_default: assert property (@(posedge clock) disable iff (!rstn) // [R3]
    core_rst |=> !spread_q)
    else $error("Spread setting not restored");
  a_por_release: assert property (@(posedge clock) disable iff (!rstn) // [R4]
    $rose(por_n) ##1 por_n [*2] |-> por_rst_n)
    else $error("Supply reset released too late");
  a_sw_rst_len: assert property (@(posedge clock) disable iff (!rstn || !por_s2_q) // [R6]
    $rose(sw_active) |-> sw_active ##1 sw_active ##1 !sw_active)
    else $error("Software reset not two clocks");
  a_sw_keeps_por: assert property (@(posedge clock) disable iff (!rstn) // [R9]
    (sw_active && por_s2_q) |=> por_rst_n)
    else $error("Software reset touched supply reset");
  a_flag_set: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    core_rst |=> flag_q)
    else $error("Reset flag not set after reset");
  a_flag_clear: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    (read_flag && !core_rst) |=> !flag_q)
    else $error("Reset flag not cleared by read");
  a_check_gate: assert property (@(posedge clock) disable iff (!rstn) // [R12]
    !passed |-> bridge_tristate)
    else $error("Bridge enabled before pass");
  a_pass_sticky: assert property (@(posedge clock) disable iff (core_rst) // [R13]
    (passed && trig_req) |=> passed && !lower_q)
    else $error("Trigger accepted after pass");
  a_start_lower: assert property (@(posedge clock) disable iff (core_rst) // [R14]
    start |=> lower_q && run && !ref_exp && !dur_exp && !fil_exp)
    else $error("Start did not lower threshold");
  a_grade_pass: assert property (@(posedge clock) disable iff (core_rst) // [R15]
    (run && fil_exp && !verdict_q && ov_s2_q) |=> verdict_q && pass_q)
    else $error("Pass not graded");
  a_grade_fail: assert property (@(posedge clock) disable iff (core_rst) // [R16]
    (run && fil_exp && !verdict_q && !ov_s2_q) |=> verdict_q && !pass_q)
    else $error("Fail not graded");
  a_ref_fail: assert property (@(posedge clock) disable iff (core_rst) // [R17]
    (run && ref_exp && !fil_exp && !verdict_q) |=> verdict_q && !pass_q)
    else $error("Unfinished filter not failed");
  a_ref_restore: assert property (@(posedge clock) disable iff (core_rst) // [R18]
    (ref_exp && !start) |=> !lower_q)
    else $error("Threshold not restored");
  a_fil_restart: assert property (@(posedge clock) disable iff (core_rst) // [R19]
    (run && ov_rise && !verdict_q) |=> !fil_exp)
    else $error("Filter not restarted");
  a_arm_edge: assert property (@(posedge clock) disable iff (core_rst) // [R20]
    $rose(armed_q) |-> $past(pwm_edge) && $past(passed))
    else $error("Bridge armed without PWM edge");
  a_dur_done: assert property (@(posedge clock) disable iff (core_rst) // [R21]
    (run && dur_exp && !start) |=> self_check_done && verdict_q)
    else $error("Done not set at duration end");
  // Checks the answer word itself, not the status expression
  a_status_code: assert property (@(posedge clock) disable iff (core_rst) // [R22]
    (frame.rx_valid && is_cmd(frame.rx_word, `RSC_CMD_STREQ) && is_sub(frame.rx_word, `RSC_SUB_A))
    |=> (tx_q[`RSC_ST_HI] == $past(self_check_done)) &&
        (tx_q[`RSC_ST_HI-1:`RSC_ST_LO] == {2{$past(self_check_done && pass_q)}}))
    else $error("Status code wrong");
endmodule

// >>> sim/rsc_mcu_model.sv
`timescale 1ns/1ps
module rsc_mcu_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic alt_q;
  logic sdo_seen;

  initial begin
    sclk  = 1'b0;
    cs_n  = 1'b1;
    sdi   = 1'b0;
    alt_q = 1'b0;
  end

  // Released line shows a changing pattern, never a stale bit
  always @(posedge clock) begin
    alt_q <= ~alt_q;
  end
  assign sdo_seen = sdo_oe ? sdo : alt_q;

  // Mode 0, MSB first, 8 clocks per bit; clock idles low outside frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clock);
      cs_n <= 1'b0;
      sclk <= 1'b0;
      sdi  <= tx[i];
      repeat (4) @(posedge clock);
      @(negedge clock);
      rx[i] = sdo_seen;
      @(posedge clock);
      sclk <= 1'b1;
      repeat (2) @(posedge clock);
    end
    @(posedge clock);
    sclk <= 1'b0;
    sdi  <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    // Gap covers sync, decode and answer update of this frame
    repeat (8) @(posedge clock);
  endtask

  task automatic software_reset_cmd();
    logic [15:0] d;
    xfer({4'h2, 1'b0, 2'h1, 9'h000}, d);
  endtask

  task automatic trigger();
    logic [15:0] d;
    // Trigger alone in D8; the reset code field stays 00
    xfer({4'h2, 3'h0, 1'b1, 8'h00}, d);
  endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
`define RSC_CHECK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
    end \
  end

module tb;
  localparam int REF = 3000;
  localparam int DUR = 3500;
  logic        clock;
  logic        rstn;
  logic        por_n;
  logic        ov_comp;
  logic        pwm;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        bridge_tristate;
  logic        ov_threshold_lower;
  logic        spread_disable;
  logic        self_check_done;
  logic        por_rst_n;
  logic        int_rst_n;
  logic [15:0] ans;
  int          fails;
  int          total_checks;
  int          cycles;
  int          rst_low;
  int          por_low;
  int          low_cyc;
  int          bad_br;

  rsc_top #(.REF_CYC(REF), .DUR_CYC(DUR)) uut (
    .clock(clock), .rstn(rstn), .por_n(por_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .ov_comp(ov_comp), .pwm(pwm),
    .bridge_tristate(bridge_tristate), .ov_threshold_lower(ov_threshold_lower),
    .spread_disable(spread_disable), .self_check_done(self_check_done),
    .por_rst_n(por_rst_n), .int_rst_n(int_rst_n)
  );

  rsc_mcu_model u_mcu (
    .clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic complete_run();
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (int_rst_n === 1'b0) rst_low <= rst_low + 1;
    if (por_rst_n === 1'b0) por_low <= por_low + 1;
    if (ov_threshold_lower === 1'b1) low_cyc <= low_cyc + 1;
    if (int_rst_n === 1'b0 && bridge_tristate !== 1'b1) bad_br <= bad_br + 1;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end

  // Answer of a frame arrives in the frame after it
  task automatic ask(input logic [15:0] w);
    logic [15:0] d;
    u_mcu.xfer(w, d);
    u_mcu.xfer(16'h0000, ans);
  endtask

  task automatic run_check(input int rise_at);
    int t0;
    @(posedge clock);
    ov_comp <= 1'b0;
    low_cyc = 0;
    u_mcu.trigger();
    t0 = cycles;
    @(negedge clock);
    `RSC_CHECK("lowered", 1'b1, ov_threshold_lower)
    if (rise_at >= 0) begin
      repeat (rise_at) @(posedge clock);
      ov_comp <= 1'b1;
    end
    while (self_check_done !== 1'b1 && cycles - t0 < DUR + 50) @(negedge clock);
    `RSC_CHECK("done time", 1'b1, (cycles - t0 >= DUR - 6) && (cycles - t0 <= DUR + 3))
    `RSC_CHECK("ref time", 1'b1, (low_cyc >= REF - 2) && (low_cyc <= REF + 3))
    `RSC_CHECK("restored", 1'b0, ov_threshold_lower)
    `RSC_CHECK("tri held", 1'b1, bridge_tristate)
    ask(16'h8000);
  endtask

  task automatic t_defaults();
    ask(16'h7004);
    `RSC_CHECK("flag set", 1'b1, ans[11])
    ask(16'h7004);
    `RSC_CHECK("flag cleared", 1'b0, ans[11])
    ask(16'h7001);
    `RSC_CHECK("spread echo", 1'b0, ans[2])
    ask(16'h8000);
    `RSC_CHECK("status idle", 3'h0, ans[8:6])
    `RSC_CHECK("tri idle", 1'b1, bridge_tristate)
    `RSC_CHECK("spread idle", 1'b0, spread_disable)
  endtask

  task automatic t_spread();
    ask(16'h4004);
    `RSC_CHECK("spread set", 1'b1, spread_disable)
    `RSC_CHECK("spread answer", 1'b1, ans[2])
    ask(16'h7001);
    `RSC_CHECK("spread echo", 1'b1, ans[2])
  endtask

  task automatic t_selfcheck();
    run_check(-1);
    `RSC_CHECK("plain fail", 3'h4, ans[8:6])
    run_check(2000);
    `RSC_CHECK("late edge fail", 3'h4, ans[8:6])
    run_check(10);
    `RSC_CHECK("pass", 3'h7, ans[8:6])
    @(posedge clock);
    ov_comp <= 1'b0;
    u_mcu.trigger();
    `RSC_CHECK("no rerun", 1'b0, ov_threshold_lower)
    ask(16'h8000);
    `RSC_CHECK("pass kept", 3'h7, ans[8:6])
    repeat (20) @(posedge clock);
    `RSC_CHECK("wait edge", 1'b1, bridge_tristate)
    pwm <= 1'b1;
    repeat (8) @(posedge clock);
    `RSC_CHECK("armed", 1'b0, bridge_tristate)
  endtask

  task automatic t_swreset();
    logic [1:0] code;
    for (int c = 0; c < 4; c++) begin
      if (c == 1) continue;
      code = 2'(c);
      rst_low = 0;
      u_mcu.xfer({4'h2, 1'b0, code, 9'h000}, ans);
      `RSC_CHECK("ignored code", 0, rst_low)
    end
    `RSC_CHECK("spread kept", 1'b1, spread_disable)
    rst_low = 0;
    por_low = 0;
    u_mcu.software_reset_cmd();
    `RSC_CHECK("reset length", 2, rst_low)
    `RSC_CHECK("supply reset kept", 0, por_low)
    `RSC_CHECK("spread default", 1'b0, spread_disable)
    `RSC_CHECK("tri again", 1'b1, bridge_tristate)
    ask(16'h7004);
    `RSC_CHECK("flag after sw", 1'b1, ans[11])
  endtask

  task automatic t_por();
    int n;
    ask(16'h4004);
    @(posedge clock);
    por_n <= 1'b0;
    @(negedge clock);
    `RSC_CHECK("async reset", 1'b0, int_rst_n)
    `RSC_CHECK("supply tri", 1'b1, bridge_tristate)
    repeat (4) @(posedge clock);
    `RSC_CHECK("supply reset", 1'b0, por_rst_n)
    por_n <= 1'b1;
    n = 0;
    while (por_rst_n !== 1'b1 && n < 15000) begin
      @(negedge clock);
      n++;
    end
    `RSC_CHECK("release bound", 1'b1, por_rst_n)
    `RSC_CHECK("spread restored", 1'b0, spread_disable)
    `RSC_CHECK("not done", 1'b0, self_check_done)
    ask(16'h7004);
    `RSC_CHECK("flag after supply", 1'b1, ans[11])
  endtask

  initial begin
    rstn         = 1'b0;
    por_n        = 1'b0;
    ov_comp      = 1'b0;
    pwm          = 1'b0;
    fails        = 0;
    total_checks = 0;
    cycles       = 0;
    rst_low      = 0;
    por_low      = 0;
    low_cyc      = 0;
    bad_br       = 0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    `RSC_CHECK("power-up tri", 1'b1, bridge_tristate)
    @(posedge clock);
    rstn  <= 1'b1;
    por_n <= 1'b1;
    repeat (6) @(posedge clock);
    t_defaults();
    t_spread();
    t_selfcheck();
    t_swreset();
    t_por();
    `RSC_CHECK("reset bridge", 0, bad_br)
    complete_run();
  end
endmodule
